// >>> pm_irq_cfg.svh
// Purpose: constants for the power management and port interrupt block
// Assumes: register offsets are byte offsets on the local register port
// Notes:   header holds definitions only
`ifndef PM_IRQ_CFG_SVH
`define PM_IRQ_CFG_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define OFS_PMCS        4'h0
`define OFS_SRC         4'h4
`define OFS_IEN         4'h8

// ------------------------------------------------------------
// power_mgmt_ctrl_status fields
// ------------------------------------------------------------
`define SEL_MSB         18
`define SEL_LSB         11
`define SEL_RST         8'h88
`define BIT_D3W         10
`define BIT_D2W         9
`define BIT_EN          8
`define BIT_WKP         7
`define BIT_STAT        6
`define BIT_DRV         5
`define BIT_AUX         4
`define CUR_MSB         3
`define CUR_LSB         2
`define REQ_MSB         1
`define REQ_LSB         0
`define SEL_D0          8'h01
`define SEL_D3          8'h04

// ------------------------------------------------------------
// port_irq_source / port_irq_enable fields
// ------------------------------------------------------------
`define SRC_W           13
`define SRC_MASK        13'h1bff
`define IEN_RST         13'h0008
`define S_DMA           12
`define S_BUS_RESET_CHANGE          11
`define S_SERIAL_MEM_READY         9
`define S_CONFIG_CHECKSUM_ERROR        8
`define S_CONFIG_LOAD_DONE       7
`define S_MOK           6
`define S_FALL          5
`define S_RISE          4
`define S_HOST_SW_REQUEST        3
`define S_MABORT        2
`define S_TABORT        1
`define S_PWR           0

// ------------------------------------------------------------
// link clock activity timing
// ------------------------------------------------------------
`define CLK_NS          4
`define PCLK_IDLE_NS    64
`define PCLK_IDLE_CYC   5'(`PCLK_IDLE_NS / `CLK_NS)
`endif

// >>> pm_irq_pkg.sv
// Purpose: shared types of the power management and interrupt block
// Assumes: constants come from pm_irq_cfg.svh
// Notes:   none
`include "pm_irq_cfg.svh"
package pm_irq_pkg;
    typedef enum logic [1:0] {D0, D1, D2, D3} power_state_type;
    typedef logic [`SRC_W-1:0] src_vec_type;
endpackage

// >>> sync2.sv
// Purpose: two flip-flop synchroniser for pins from another domain
// Assumes: bits are independent levels
// Notes:   no reset, so the live pin level is never disturbed
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_state_type;

    sync_state_type s_reg;
    sync_state_type s_next;

    // first stage feeds only the second
    always_comb
    begin
        s_next.meta   = d;
        s_next.stable = s_reg.meta;
    end

    always_ff @(posedge clk)
    begin
        s_reg <= s_next;
    end

    assign q = s_reg.stable;
endmodule // sync2
`default_nettype wire

// >>> clk_monitor.sv
// Purpose: tells whether the sampled link clock is toggling
// Assumes: clk_s is already synchronised
// Notes:   active means an edge within the idle window
`include "pm_irq_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module clk_monitor
    import pm_irq_pkg::*;
(
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic clk_s,
    output logic      active
);
    typedef struct packed {
        logic       prev;
        logic [4:0] idle;
    } mon_state_type;

    mon_state_type s_reg;
    mon_state_type s_next;

    // count cycles since the last edge, saturating
    always_comb
    begin
        s_next      = s_reg;
        s_next.prev = clk_s;
        if (clk_s != s_reg.prev)
            s_next.idle = '0;
        else if (s_reg.idle != `PCLK_IDLE_CYC)
            s_next.idle = s_reg.idle + 5'h01;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            s_reg <= '{prev: 1'b0, idle: `PCLK_IDLE_CYC};
        else
            s_reg <= s_next;
    end

    assign active = s_reg.idle != `PCLK_IDLE_CYC;
endmodule // clk_monitor
`default_nettype wire

// >>> pm_irq_regs.sv
// Purpose: power management control/status and port interrupt sources
// Assumes: event inputs are one-cycle pulses on clk; pins are async
// Notes:   read data appears one cycle after reg_rd
`include "pm_irq_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module pm_irq_regs
    import pm_irq_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [3:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [31:0] reg_wdata,
    output logic      [31:0] reg_rdata,
    input  wire logic        pci_clk,
    input  wire logic        pci_rst_n,
    input  wire logic        wake_pin_n,
    input  wire logic        aux_det_pin,
    input  wire logic        host_state_wr,
    input  wire logic [1:0]  host_state_val,
    input  wire logic        host_pme_en_wr,
    input  wire logic        host_pme_en_val,
    input  wire logic        host_pme_stat_clr,
    input  wire logic        host_core_irq_wr,
    input  wire logic        dma_halt_evt,
    input  wire logic        eeprom_ready_evt,
    input  wire logic        cfg_err_evt,
    input  wire logic        cfg_done_evt,
    input  wire logic        master_done_evt,
    input  wire logic        master_abort_evt,
    input  wire logic        target_abort_evt,
    input  wire logic        core_clk_on,
    input  wire logic        deep_sleep_warm_on_wake,
    input  wire logic        light_sleep_warm_on_wake,
    output logic             pme_out,
    output logic      [1:0]  cur_state_out,
    output logic             warm_rst,
    output logic             irq_out
);
    typedef struct packed {
        logic            primed;
        logic            warm;
        logic [7:0]      sel;
        logic            pme_en;
        logic            pme_stat;
        power_state_type cur;
        logic [1:0]      req;
        src_vec_type     src;
        src_vec_type     ien;
        logic            done_seen;
        logic            err_seen;
        logic            wake_q;
        logic            bus_reset_change_q;
        logic [31:0]     rdata;
    } regs_state_type;

    localparam regs_state_type ST_RST = '{
        primed: 1'b0, warm: 1'b0, sel: `SEL_RST, pme_en: 1'b0,
        pme_stat: 1'b0, cur: D0, req: 2'h0, src: '0, ien: `IEN_RST,
        done_seen: 1'b0, err_seen: 1'b0, wake_q: 1'b1, bus_reset_change_q: 1'b0,
        rdata: 32'h0000_0000};

    regs_state_type s_reg;
    regs_state_type s_next;

    logic [3:0]  pins_s;
    logic        pclk_s;
    logic        bus_reset_change_n_s;
    logic        wake_s;
    logic        aux_s;
    logic        pclk_on;
    logic        wr_pmcs;
    logic        wr_src;
    logic        wr_ien;
    logic        wk_fall;
    logic        wk_rise;
    logic        bus_reset_change_chg;
    logic        hw_pme;
    logic        warm_cond;
    src_vec_type src_set;
    src_vec_type src_clr;
    src_vec_type warm_src;

    // ------------------------------------------------------------
    // pin synchronisers and link clock monitor
    // ------------------------------------------------------------
    sync2 #(.W(4)) u_sync (
        .clk (clk),
        .d   ({pci_clk, pci_rst_n, wake_pin_n, aux_det_pin}),
        .q   (pins_s)
    );

    assign pclk_s   = pins_s[3];
    assign bus_reset_change_n_s = pins_s[2];
    assign wake_s   = pins_s[1];
    assign aux_s    = pins_s[0];

    clk_monitor u_mon (
        .clk    (clk),
        .rstn   (rstn),
        .clk_s  (pclk_s),
        .active (pclk_on)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------

    // hardware event select code matches requested state
    function automatic logic sel_hit(input logic [7:0] sel, input logic [1:0] req);
        logic ok;
        ok = (sel >= `SEL_D0) && (sel <= `SEL_D3);
        sel_hit = ok && ((sel - `SEL_D0) == {6'h00, req});
    endfunction

    // read image of the control/status register
    function automatic logic [31:0] pmcs_image(input regs_state_type st,
                                               input logic wk, input logic ax);
        logic [31:0] v;
        v                     = 32'h0000_0000;
        v[`SEL_MSB:`SEL_LSB]  = st.sel;
        v[`BIT_D3W]           = deep_sleep_warm_on_wake;
        v[`BIT_D2W]           = light_sleep_warm_on_wake;
        v[`BIT_EN]            = st.pme_en;
        v[`BIT_WKP]           = wk;
        v[`BIT_STAT]          = st.pme_stat;
        v[`BIT_DRV]           = st.pme_en & st.pme_stat;
        v[`BIT_AUX]           = ax;
        v[`CUR_MSB:`CUR_LSB]  = st.cur;
        v[`REQ_MSB:`REQ_LSB]  = st.req;
        pmcs_image = v;
    endfunction

    // ------------------------------------------------------------
    // event decode
    // ------------------------------------------------------------
    assign wr_pmcs  = reg_wr && (reg_addr == `OFS_PMCS);
    assign wr_src   = reg_wr && (reg_addr == `OFS_SRC);
    assign wr_ien   = reg_wr && (reg_addr == `OFS_IEN);
    assign wk_fall  = s_reg.primed && s_reg.wake_q && !wake_s;
    assign wk_rise  = s_reg.primed && !s_reg.wake_q && wake_s;
    assign bus_reset_change_chg = s_reg.primed && (s_reg.bus_reset_change_q != bus_reset_change_n_s);
    assign hw_pme   = !wake_s && sel_hit(s_reg.sel, s_reg.req);

    // warm reset on wake from deep or light sleep
    assign warm_cond = wk_fall && bus_reset_change_n_s && pclk_on
        && ((s_reg.cur == D3 && deep_sleep_warm_on_wake)
         || (s_reg.cur == D2 && light_sleep_warm_on_wake));

    // source set terms, all in one vector
    always_comb
    begin
        src_set             = '0;
        src_set[`S_DMA]     = dma_halt_evt;
        src_set[`S_BUS_RESET_CHANGE]    = bus_reset_change_chg;
        src_set[`S_SERIAL_MEM_READY]   = eeprom_ready_evt;
        src_set[`S_CONFIG_CHECKSUM_ERROR]  = cfg_err_evt;
        src_set[`S_CONFIG_LOAD_DONE] = cfg_done_evt;
        src_set[`S_MOK]     = master_done_evt;
        src_set[`S_FALL]    = wk_fall;
        src_set[`S_RISE]    = wk_rise;
        src_set[`S_HOST_SW_REQUEST]  = host_core_irq_wr;
        src_set[`S_MABORT]  = master_abort_evt;
        src_set[`S_TABORT]  = target_abort_evt;
        src_set[`S_PWR]     = host_state_wr && core_clk_on
                              && (host_state_val != s_reg.req);
    end

    // write-one clear image and warm reload of config status
    always_comb
    begin
        src_clr              = wr_src ? reg_wdata[`SRC_W-1:0] : '0;
        warm_src             = '0;
        warm_src[`S_CONFIG_CHECKSUM_ERROR]  = s_reg.err_seen;
        warm_src[`S_CONFIG_LOAD_DONE] = s_reg.done_seen;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        s_next        = s_reg;
        s_next.primed = 1'b1;
        s_next.warm   = warm_cond;
        s_next.wake_q = wake_s;
        s_next.bus_reset_change_q = bus_reset_change_n_s;

        // host clear first, so a software or hardware set wins
        if (host_pme_stat_clr)
            s_next.pme_stat = 1'b0;

        // software writes of the control/status register
        if (wr_pmcs)
        begin
            s_next.sel = reg_wdata[`SEL_MSB:`SEL_LSB];
            s_next.cur = power_state_type'(reg_wdata[`CUR_MSB:`CUR_LSB]);
            if (reg_wdata[`BIT_EN])
            begin
                s_next.pme_en   = 1'b0;
                s_next.pme_stat = 1'b0;
            end
            else if (reg_wdata[`BIT_STAT])
                s_next.pme_stat = 1'b1;
        end

        // host side of the event bits, hardware set wins
        if (host_pme_en_wr)
            s_next.pme_en = host_pme_en_val;
        if (hw_pme)
            s_next.pme_stat = 1'b1;

        // requested state capture, cleared by bus reset
        if (host_state_wr)
            s_next.req = host_state_val;
        if (!bus_reset_change_n_s)
            s_next.req = 2'h0;

        // sources: set wins over clear
        s_next.src = ((s_reg.src & ~src_clr) | src_set) & `SRC_MASK;
        if (wr_ien)
            s_next.ien = reg_wdata[`SRC_W-1:0] & `SRC_MASK;

        // remember config outcome for warm reloads
        if (cfg_done_evt)
            s_next.done_seen = 1'b1;
        if (cfg_err_evt)
            s_next.err_seen = 1'b1;

        // warm reset clears the enable bit, sets status only on a live select match, reloads config status sources from the seen flags, restores reset enables
        if (s_reg.warm)
        begin
            s_next.pme_en   = 1'b0;
            s_next.pme_stat = hw_pme;
            s_next.src      = warm_src | src_set;
            s_next.ien      = `IEN_RST;
        end

        // register read data, unmapped reads give zero
        if (reg_rd)
        begin
            unique case (reg_addr)
                `OFS_PMCS: s_next.rdata = pmcs_image(s_reg, wake_s, aux_s);
                `OFS_SRC:  s_next.rdata = {19'h0, s_reg.src};
                `OFS_IEN:  s_next.rdata = {19'h0, s_reg.ien};
                default:   s_next.rdata = 32'h0000_0000;
            endcase
        end
    end

    // device reset restores everything
    always_ff @(posedge clk)
    begin
        if (!rstn)
            s_reg <= ST_RST;
        else
            s_reg <= s_next;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata     = s_reg.rdata;
    assign pme_out       = s_reg.pme_en & s_reg.pme_stat;
    assign cur_state_out = s_reg.cur;
    assign warm_rst      = s_reg.warm;
    assign irq_out       = |(s_reg.src & s_reg.ien);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    AST_SEL_RESET: assert property (
        $past(!rstn) |-> s_reg.sel == `SEL_RST && s_reg.ien == `IEN_RST)
        else $error("select or enable not at reset value");
    AST_WARM_D3: assert property (
        wk_fall && bus_reset_change_n_s && pclk_on && s_reg.cur == D3
        && deep_sleep_warm_on_wake |=> warm_rst ##1 !warm_rst)
        else $error("no single warm pulse from deep sleep wake");
    AST_WARM_GATE: assert property (
        warm_rst |-> $past(bus_reset_change_n_s) && $past(pclk_on) && $past(wk_fall))
        else $error("warm reset without bus conditions");
    AST_EN_CLEAR: assert property (
        wr_pmcs && reg_wdata[`BIT_EN] && !host_pme_en_wr && !hw_pme
        |=> !s_reg.pme_en && !s_reg.pme_stat)
        else $error("enable mirror write did not clear");
    AST_STAT_SET: assert property (
        wr_pmcs && reg_wdata[`BIT_STAT] && !reg_wdata[`BIT_EN] && !s_reg.warm
        |=> s_reg.pme_stat)
        else $error("status mirror write did not set");
    AST_DRV_READ: assert property (
        reg_rd && reg_addr == `OFS_PMCS
        |=> reg_rdata[`BIT_DRV] == ($past(s_reg.pme_en) && $past(s_reg.pme_stat)))
        else $error("driven bit wrong");
    AST_REQ_CAP: assert property (
        host_state_wr && bus_reset_change_n_s |=> s_reg.req == $past(host_state_val))
        else $error("requested state not captured");
    AST_W1C: assert property (
        wr_src && reg_wdata[`S_HOST_SW_REQUEST] && !host_core_irq_wr |=> !s_reg.src[`S_HOST_SW_REQUEST])
        else $error("host source bit not cleared");
    AST_BUS_RESET_CHANGE_CHG: assert property (
        bus_reset_change_chg |=> s_reg.src[`S_BUS_RESET_CHANGE])
        else $error("bus reset change not latched");
    AST_IRQ: assert property (
        host_core_irq_wr && s_reg.ien[`S_HOST_SW_REQUEST] && !wr_ien && !s_reg.warm |=> irq_out)
        else $error("interrupt not raised");

    AST_HW_PME: assert property (
        hw_pme |=> s_reg.pme_stat)
        else $error("wake select match did not set status");

    COV_WARM: cover property (warm_rst);
    COV_HWPME: cover property (hw_pme && !s_reg.pme_stat);
    COV_PME:  cover property (!pme_out ##1 pme_out);
    COV_IRQ:  cover property (!irq_out ##1 irq_out ##[1:20] !irq_out);
endmodule // pm_irq_regs
`default_nettype wire

// >>> pci_host_model.sv
// Purpose: far-side host model: link clock, bus reset, host config writes
// Assumes: requests launched just after rising clk edges
// Notes:   link clock stands still while link_run is low
`timescale 1ns/1ps
`default_nettype none
module pci_host_model (
    input  wire logic       clk,
    output logic            pci_clk,
    output logic            pci_rst_n,
    output logic            host_state_wr,
    output logic      [1:0] host_state_val,
    output logic            host_pme_en_wr,
    output logic            host_pme_en_val,
    output logic            host_pme_stat_clr,
    output logic            host_core_irq_wr
);
    bit link_run = 1'b1;

    // link clock, 32 ns period, only while running
    initial
    begin
        pci_clk = 1'b0;
        forever #16 if (link_run) pci_clk = ~pci_clk;
    end

    // idle levels, bus reset released
    initial
    begin
        pci_rst_n = 1'b1;
        {host_core_irq_wr, host_pme_stat_clr, host_pme_en_wr, host_state_wr} = 4'h0;
        {host_state_val, host_pme_en_val} = 3'h0;
    end

    // one-cycle host write; op bits: core irq, status clear, enable, state
    task automatic host_op(input logic [3:0] op, input logic [1:0] v);
        @(posedge clk);
        {host_core_irq_wr, host_pme_stat_clr, host_pme_en_wr, host_state_wr} <= op;
        host_state_val <= v;
        host_pme_en_val <= v[0];
        @(posedge clk);
        {host_core_irq_wr, host_pme_stat_clr, host_pme_en_wr, host_state_wr} <= 4'h0;
        host_state_val <= ~v;
        host_pme_en_val <= ~v[0];
    endtask

    // bus reset pin level, changed just after a clock edge
    task automatic set_bus_reset(input logic lvl);
        pci_rst_n <= lvl;
    endtask

    // start or stop the link clock
    task automatic set_link(input bit run);
        link_run = run;
    endtask
endmodule // pci_host_model
`default_nettype wire

// >>> pm_irq_regs_tb.sv
// Purpose: self-checking bench of the power management and interrupt block
// Assumes: register reads answer one cycle after reg_rd
// Notes:   host side comes from pci_host_model
`include "pm_irq_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module pm_irq_regs_tb
    import pm_irq_pkg::*;
;
    logic        clk, rstn, reg_wr, reg_rd, s;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic        pci_clk, pci_rst_n, wake_pin_n, aux_det_pin, core_clk_on, deep_w, light_w;
    logic        host_state_wr, host_pme_en_wr, host_pme_en_val, host_pme_stat_clr;
    logic        host_core_irq_wr, pme_out, warm_rst, irq_out;
    logic [1:0]  host_state_val, cur_state_out, cur_v;
    logic [6:0]  ev;
    logic [7:0]  sel_v;
    int          miscompares, check_count, cyc;
    int          ev_bit [7] = '{12, 9, 8, 7, 6, 2, 1};

    pm_irq_regs dut_u (
        .clk, .rstn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .pci_clk, .pci_rst_n, .wake_pin_n, .aux_det_pin, .host_state_wr,
        .host_state_val, .host_pme_en_wr, .host_pme_en_val, .host_pme_stat_clr,
        .host_core_irq_wr, .dma_halt_evt(ev[0]), .eeprom_ready_evt(ev[1]),
        .cfg_err_evt(ev[2]), .cfg_done_evt(ev[3]), .master_done_evt(ev[4]),
        .master_abort_evt(ev[5]), .target_abort_evt(ev[6]), .core_clk_on,
        .deep_sleep_warm_on_wake(deep_w), .light_sleep_warm_on_wake(light_w),
        .pme_out, .cur_state_out, .warm_rst, .irq_out
    );
    pci_host_model host_u (
        .clk, .pci_clk, .pci_rst_n, .host_state_wr, .host_state_val, .host_pme_en_wr,
        .host_pme_en_val, .host_pme_stat_clr, .host_core_irq_wr
    );

    // ------------------------------------------------------------
    // clock, timeout and helpers
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        chk(reg_rdata & m, e);
    endtask
    // control word write keeps select and current state fields
    task automatic pm_wr(input logic [31:0] extra);
        wr(`OFS_PMCS, {13'h0, sel_v, 11'h0} | {28'h0, cur_v, 2'b0} | extra);
    endtask
    // drop wake pin, watch for a warm reset pulse, release
    task automatic wake_try(output logic seen);
        seen = 1'b0;
        @(posedge clk);
        wake_pin_n <= 1'b0;
        repeat (12)
        begin
            @(posedge clk);
            #1;
            if (warm_rst === 1'b1)
                seen = 1'b1;
        end
        @(posedge clk);
        wake_pin_n <= 1'b1;
        tick(8);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {wake_pin_n, aux_det_pin, core_clk_on} = 3'b111;
        {deep_w, light_w, ev} = '0;
        sel_v = `SEL_RST;
        cur_v = 2'd0;
        rstn = 1'b0;
        tick(3);
        rstn <= 1'b1;
        rd_chk(`OFS_PMCS, '1, {13'h0, `SEL_RST, 11'h090});
        rd_chk(`OFS_SRC, '1, 32'h0);
        rd_chk(`OFS_IEN, '1, 32'h8);
        rd_chk(4'hc, '1, 32'h0);
        cur_v = 2'd3;
        pm_wr(32'h0);
        tick(1);
        chk(32'(cur_state_out), 32'h3);
        host_u.host_op(4'b0001, 2'd2);
        rd_chk(`OFS_PMCS, 32'hf, 32'he);
        wr(`OFS_SRC, 32'h0);
        rd_chk(`OFS_SRC, '1, 32'h1);
        wr(`OFS_SRC, 32'h1);
        rd_chk(`OFS_SRC, '1, 32'h0);
        @(posedge clk);
        core_clk_on <= 1'b0;
        host_u.host_op(4'b0001, 2'd1);
        rd_chk(`OFS_SRC, '1, 32'h0);
        core_clk_on <= 1'b1;
        host_u.set_bus_reset(1'b0);
        tick(6);
        rd_chk(`OFS_PMCS, 32'h3, 32'h0);
        rd_chk(`OFS_SRC, 32'h800, 32'h800);
        host_u.set_bus_reset(1'b1);
        tick(6);
        wr(`OFS_SRC, 32'h1fff);
        for (int i = 0; i < 7; i++)
        begin
            @(posedge clk);
            ev[i] <= 1'b1;
            @(posedge clk);
            ev[i] <= 1'b0;
            rd_chk(`OFS_SRC, '1, 32'h1 << ev_bit[i]);
            wr(`OFS_SRC, 32'h1 << ev_bit[i]);
        end
        host_u.host_op(4'b1000, 2'd0);
        tick(1);
        chk(32'(irq_out), 32'h1);
        wr(`OFS_IEN, 32'h0);
        tick(1);
        chk(32'(irq_out), 32'h0);
        wr(`OFS_SRC, 32'h8);
        pm_wr(32'h40);
        rd_chk(`OFS_PMCS, 32'h160, 32'h40);
        host_u.host_op(4'b0010, 2'd1);
        tick(1);
        chk(32'(pme_out), 32'h1);
        rd_chk(`OFS_PMCS, 32'h160, 32'h160);
        pm_wr(32'h0);
        rd_chk(`OFS_PMCS, 32'h160, 32'h160);
        host_u.host_op(4'b0100, 2'd0);
        rd_chk(`OFS_PMCS, 32'h160, 32'h100);
        pm_wr(32'h40);
        pm_wr(32'h140);
        rd_chk(`OFS_PMCS, 32'h160, 32'h0);
        host_u.host_op(4'b0010, 2'd1);
        pm_wr(32'h100);
        rd_chk(`OFS_PMCS, 32'h160, 32'h0);
        chk(32'(pme_out), 32'h0);
        for (int k = 0; k < 4; k++)
        begin
            host_u.host_op(4'b0001, 2'(k));
            sel_v = 8'(k + 1);
            pm_wr(32'h0);
            wake_try(s);
            rd_chk(`OFS_PMCS, 32'hc0, 32'hc0);
            pm_wr(32'h100);
        end
        sel_v = `SEL_RST;
        wr(`OFS_IEN, 32'hbff);
        @(posedge clk);
        deep_w <= 1'b1;
        wake_try(s);
        chk(32'(s), 32'h1);
        rd_chk(`OFS_SRC, '1, 32'h190);
        rd_chk(`OFS_IEN, '1, 32'h8);
        host_u.set_link(1'b0);
        tick(20);
        wake_try(s);
        chk(32'(s), 32'h0);
        host_u.set_link(1'b1);
        tick(8);
        host_u.set_bus_reset(1'b0);
        wake_try(s);
        chk(32'(s), 32'h0);
        host_u.set_bus_reset(1'b1);
        deep_w <= 1'b0;
        pm_wr(32'h100);
        wake_try(s);
        chk(32'(s), 32'h0);
        rd_chk(`OFS_PMCS, 32'h40, 32'h0);
        cur_v = 2'd2;
        pm_wr(32'h0);
        light_w <= 1'b1;
        wake_try(s);
        chk(32'(s), 32'h1);
        light_w <= 1'b0;
        wake_try(s);
        chk(32'(s), 32'h0);
        rd_chk(`OFS_PMCS, 32'hc, 32'h8);
        rstn <= 1'b0;
        tick(3);
        rstn <= 1'b1;
        rd_chk(`OFS_PMCS, '1, {13'h0, `SEL_RST, 11'h090});
        rd_chk(`OFS_SRC, '1, 32'h0);
        rd_chk(`OFS_IEN, '1, 32'h8);
        wrap_up();
    end
endmodule // pm_irq_regs_tb
`default_nettype wire
